// *** common/ccmc_pkg.sv ***
// package: register map, field layout and mode codes of the channel mode control
package ccmc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] MODE_CFG_OFFS = 4'h0;
  localparam logic [ADDR_W-1:0] COMPARE_OFFS = 4'h4;
  localparam logic [ADDR_W-1:0] ENABLE_OFFS = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 4'hC;

  // mode register fields
  localparam int DIR_LSB = 0;
  localparam int FAST_BIT = 2;
  localparam int PRELOAD_BIT = 3;
  localparam int MODE_LSB = 4;
  // enable register fields
  localparam int CHAN_EN_BIT = 0;
  localparam int PROT_LSB = 4;

  localparam logic [DATA_W-1:0] MODE_CFG_RESET = 16'h0000;
  localparam logic [1:0] PROT_LOCK_LEVEL = 2'h3;

  typedef enum logic [1:0] {
    CCMC_DIR_OUTPUT = 2'h0,
    CCMC_DIR_IN_ONE = 2'h1,
    CCMC_DIR_IN_TWO = 2'h2,
    CCMC_DIR_IN_TRIG = 2'h3
  } ccmc_dir_e;

  typedef enum logic [2:0] {
    CCMC_OC_FREEZE = 3'h0,
    CCMC_OC_SET_MATCH = 3'h1,
    CCMC_OC_CLR_MATCH = 3'h2,
    CCMC_OC_TOGGLE = 3'h3,
    CCMC_OC_FORCE_LOW = 3'h4,
    CCMC_OC_FORCE_HIGH = 3'h5,
    CCMC_OC_PWM_ONE = 3'h6,
    CCMC_OC_PWM_TWO = 3'h7
  } ccmc_ocmode_e;

  typedef struct packed {
    ccmc_ocmode_e outputCompareMode;
    logic comparePreloadEnable;
    logic fastResponseEnable;
    ccmc_dir_e channelDirectionSelect;
  } ccmc_mode_s;

endpackage

// *** rtl/ccmc_channel_mode.sv ***
// channel one mode control: direction, preload, fast response, compare modes
//
// Behaviour
// [R1] nonzero direction selects input one, two, trigger
// [R2] direction code 00 makes channel output
// [R3] direction writable only while channel disabled
// [R4] fast enable bit two bypasses trigger delay
// [R5] preload off: compare write acts immediately
// [R6] preload on: compare loads on update event
// [R7] lock level three freezes preload, mode; code freezes them only while the channel is output (direction 00)
// [R8] software: PWM without preload needs single-pulse
// [R9] mode 000 leaves reference unchanged
// [R10] mode 001 sets reference high on match
// [R11] mode 010 sets reference low on match
// [R12] mode 011 toggles reference on match
// [R13] mode 100 forces reference low
// [R14] mode 101 forces reference high
// [R15] mode 110 high while counter below compare
// [R16] mode 111 high while counter above compare
// [R17] PWM level follows comparison and freeze exit
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module ccmc_channel_mode #(
  parameter int CNT_W = 16
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ccmc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ccmc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [ccmc_pkg::DATA_W-1:0] regRdata,
  input wire logic [CNT_W-1:0] counterValue,
  input wire logic updateEvent,
  input wire logic triggerEvent,
  input wire logic timerInputOne,
  input wire logic timerInputTwo,
  input wire logic internalTriggerSource,
  output logic channelCaptureInput,
  output logic channelReferenceOutput,
  output logic [CNT_W-1:0] compareValue
);

  initial
  begin
    if (CNT_W < 1 || CNT_W > ccmc_pkg::DATA_W)
      $error("counter width must lie between 1 and the data width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  ccmc_pkg::ccmc_mode_s modeCfg_reg;
  logic channelEnable_reg;
  logic [1:0] protLevel_reg;
  logic [CNT_W-1:0] preload_reg;
  logic [CNT_W-1:0] compareValue_reg;
  logic [ccmc_pkg::DATA_W-1:0] regRdata_reg;
  logic channelReferenceOutput_reg;
  logic channelReferenceOutput_next;
  logic [2:0] inputSync_reg;
  logic [2:0] inputMeta_reg;
  logic channelCaptureInput_reg;

  logic isOutput;
  logic cfgLocked;
  logic writeMode;
  logic writeCompare;
  logic writeEnable;
  ccmc_pkg::ccmc_mode_s wrMode;

  assign isOutput = modeCfg_reg.channelDirectionSelect == ccmc_pkg::CCMC_DIR_OUTPUT; // R2
  assign cfgLocked = isOutput && (protLevel_reg == ccmc_pkg::PROT_LOCK_LEVEL); // R7
  assign writeMode = regWrite && (regAddr == ccmc_pkg::MODE_CFG_OFFS);
  assign writeCompare = regWrite && (regAddr == ccmc_pkg::COMPARE_OFFS);
  assign writeEnable = regWrite && (regAddr == ccmc_pkg::ENABLE_OFFS);
  assign wrMode = ccmc_pkg::ccmc_mode_s'(regWdata[6:0]);

  ////////////////////////////////////////////////////////////////////////////
  // mode register

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      modeCfg_reg <= ccmc_pkg::ccmc_mode_s'(ccmc_pkg::MODE_CFG_RESET[6:0]);
    else if (writeMode)
    begin
      if (!channelEnable_reg)
        modeCfg_reg.channelDirectionSelect <= wrMode.channelDirectionSelect; // R3
      modeCfg_reg.fastResponseEnable <= wrMode.fastResponseEnable; // R4
      if (!cfgLocked)
      begin
        modeCfg_reg.comparePreloadEnable <= wrMode.comparePreloadEnable; // R7
        modeCfg_reg.outputCompareMode <= wrMode.outputCompareMode; // R7
      end
    end
  end

  // channel enable and protection level
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      channelEnable_reg <= 1'b0;
      protLevel_reg <= 2'h0;
    end
    else if (writeEnable)
    begin
      channelEnable_reg <= regWdata[ccmc_pkg::CHAN_EN_BIT];
      protLevel_reg <= regWdata[ccmc_pkg::PROT_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value with optional preload

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      preload_reg <= '0;
    else if (writeCompare)
      preload_reg <= regWdata[CNT_W-1:0];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      compareValue_reg <= '0;
    else if (writeCompare && !modeCfg_reg.comparePreloadEnable)
      compareValue_reg <= regWdata[CNT_W-1:0]; // R5
    else if (updateEvent && modeCfg_reg.comparePreloadEnable)
      compareValue_reg <= preload_reg; // R6
  end

  assign compareValue = compareValue_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reference output generation

  logic match;
  logic below;
  logic above;
  logic forceMatch;

  assign match = counterValue == compareValue_reg;
  assign below = counterValue < compareValue_reg;
  assign above = counterValue > compareValue_reg;
  // fast response treats a trigger event as an immediate match
  assign forceMatch = match || (modeCfg_reg.fastResponseEnable && triggerEvent); // R4

  always_comb
  begin
    channelReferenceOutput_next = channelReferenceOutput_reg;
    if (isOutput)
    begin
      case (modeCfg_reg.outputCompareMode)
        ccmc_pkg::CCMC_OC_FREEZE: channelReferenceOutput_next = channelReferenceOutput_reg; // R9
        ccmc_pkg::CCMC_OC_SET_MATCH:
          if (forceMatch)
            channelReferenceOutput_next = 1'b1; // R10
        ccmc_pkg::CCMC_OC_CLR_MATCH:
          if (forceMatch)
            channelReferenceOutput_next = 1'b0; // R11
        ccmc_pkg::CCMC_OC_TOGGLE:
          if (forceMatch)
            channelReferenceOutput_next = !channelReferenceOutput_reg; // R12
        ccmc_pkg::CCMC_OC_FORCE_LOW: channelReferenceOutput_next = 1'b0; // R13
        ccmc_pkg::CCMC_OC_FORCE_HIGH: channelReferenceOutput_next = 1'b1; // R14
        // level recomputed every cycle, so it moves only with the comparison
        ccmc_pkg::CCMC_OC_PWM_ONE: channelReferenceOutput_next = below; // R15 R17
        ccmc_pkg::CCMC_OC_PWM_TWO: channelReferenceOutput_next = above; // R16 R17
        default: channelReferenceOutput_next = channelReferenceOutput_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      channelReferenceOutput_reg <= 1'b0;
    else
      channelReferenceOutput_reg <= channelReferenceOutput_next;
  end

  assign channelReferenceOutput = channelReferenceOutput_reg;

  ////////////////////////////////////////////////////////////////////////////
  // capture input source selection

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      inputMeta_reg <= 3'h0;
      inputSync_reg <= 3'h0;
    end
    else
    begin
      inputMeta_reg <= {internalTriggerSource, timerInputTwo, timerInputOne};
      inputSync_reg <= inputMeta_reg;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      channelCaptureInput_reg <= 1'b0;
    else
    begin
      case (modeCfg_reg.channelDirectionSelect)
        ccmc_pkg::CCMC_DIR_IN_ONE: channelCaptureInput_reg <= inputSync_reg[0]; // R1
        ccmc_pkg::CCMC_DIR_IN_TWO: channelCaptureInput_reg <= inputSync_reg[1]; // R1
        ccmc_pkg::CCMC_DIR_IN_TRIG: channelCaptureInput_reg <= inputSync_reg[2]; // R1
        default: channelCaptureInput_reg <= 1'b0; // R2
      endcase
    end
  end

  assign channelCaptureInput = channelCaptureInput_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      regRdata_reg <= '0;
    else if (regRead)
    begin
      case (regAddr)
        ccmc_pkg::MODE_CFG_OFFS: regRdata_reg <= {9'h000, modeCfg_reg};
        ccmc_pkg::COMPARE_OFFS: regRdata_reg <= ccmc_pkg::DATA_W'(preload_reg);
        ccmc_pkg::ENABLE_OFFS: regRdata_reg <= {10'h000, protLevel_reg, 3'h0, channelEnable_reg};
        ccmc_pkg::STATUS_OFFS:
          regRdata_reg <= {13'h0000, channelCaptureInput_reg, isOutput, channelReferenceOutput_reg};
        default: regRdata_reg <= '0;
      endcase
    end
    else
      regRdata_reg <= '0;
  end

  assign regRdata = regRdata_reg;

endmodule

// *** bench/ccmc_channel_mode_checker.sv ***
// assertions on the channel mode control ports
`timescale 1ns/1ps
module ccmc_channel_mode_checker #(
  parameter int CNT_W = 16
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic [CNT_W-1:0] counterValue,
  input wire logic updateEvent,
  input wire logic channelReferenceOutput,
  input wire logic [CNT_W-1:0] compareValue
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic wasMode;
  logic modeOk;
  logic [15:0] modeReg;
  wire o = modeOk && modeReg[1:0] == 2'h0;
  wire [2:0] m = modeReg[6:4];
  wire hit = counterValue == compareValue;
  wire ref1 = channelReferenceOutput;
  ////////////////////////////////////////////////////////////////
  // mode known from the last read, forgotten on any mode write
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wasMode <= 1'b0;
      modeOk <= 1'b0;
      modeReg <= 16'h0000;
    end
    else
    begin
      wasMode <= regRead && regAddr == 4'h0;
      if (regWrite && regAddr == 4'h0)
        modeOk <= 1'b0;
      else if (wasMode)
      begin
        modeOk <= 1'b1;
        modeReg <= regRdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  a_compare_cause: assert property
    ($changed(compareValue) |-> $past(regWrite) || $past(updateEvent))
    else $error("compare value moved without cause");
  a_freeze_hold: assert property (o && m == 3'h0 |=> $stable(ref1))
    else $error("freeze changed reference");
  a_set_match: assert property (o && m == 3'h1 && hit |=> ref1)
    else $error("set on match failed");
  a_clear_match: assert property (o && m == 3'h2 && hit |=> !ref1)
    else $error("clear on match failed");
  a_toggle_match: assert property
    (o && m == 3'h3 && hit |=> ref1 != $past(ref1))
    else $error("toggle on match failed");
  a_force_low: assert property (o && m == 3'h4 |=> !ref1)
    else $error("forced low failed");
  a_force_high: assert property (o && m == 3'h5 |=> ref1)
    else $error("forced high failed");
  a_pwm_one: assert property
    (o && m == 3'h6 |=> ref1 == $past(counterValue < compareValue))
    else $error("first pwm level wrong");
  a_pwm_two: assert property
    (o && m == 3'h7 |=> ref1 == $past(counterValue > compareValue))
    else $error("second pwm level wrong");
  cover property (o && m == 3'h3 && hit);
  cover property (o && m == 3'h7 && hit);
  cover property ($changed(compareValue) && $past(updateEvent));
endmodule

// *** bench/tb.sv ***
// self-checking bench for the channel mode control
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0, regRead = 1'b0, updateEvent = 1'b0, triggerEvent = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [15:0] counterValue = 16'h0000;
  logic [15:0] regRdata, compareValue;
  logic channelCaptureInput, channelReferenceOutput;
  int bad_count = 0, check_count = 0, cycles = 0;
  ccmc_channel_mode DUT (.clock, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .counterValue, .updateEvent, .triggerEvent, .timerInputOne(pins[0]),
    .timerInputTwo(pins[1]), .internalTriggerSource(pins[2]), .channelCaptureInput,
    .channelReferenceOutput, .compareValue);
  initial forever #4 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [15:0] e, s);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %0s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk("readData", e, regRdata);
  endtask
  task pulse;
    @(posedge clock);
    triggerEvent <= 1'b1;
    @(posedge clock);
    triggerEvent <= 1'b0;
    cyc(2);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'hC, 16'h0002);
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0000);
    wr(4'h8, 16'h0000);
    for (int d = 1; d < 4; d++)
    begin
      wr(4'h0, 16'(d));
      rd(4'h0, 16'(d));
      @(posedge clock);
      pins <= 3'h1 << (d - 1);
      cyc(4);
      chk("captureInput", 16'h1, 16'(channelCaptureInput));
      @(posedge clock);
      pins <= ~(3'h1 << (d - 1));
      cyc(4);
      chk("captureInput", 16'h0, 16'(channelCaptureInput));
    end
    $display("direction test done");
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h1234);
    cyc(0);
    chk("compareValue", 16'h1234, compareValue);
    wr(4'h0, 16'h0008);
    wr(4'h4, 16'h5678);
    cyc(2);
    chk("compareValue", 16'h1234, compareValue);
    rd(4'h4, 16'h5678);
    @(posedge clock);
    updateEvent <= 1'b1;
    @(posedge clock);
    updateEvent <= 1'b0;
    cyc(0);
    chk("compareValue", 16'h5678, compareValue);
    wr(4'h8, 16'h0030);
    wr(4'h0, 16'h0074);
    rd(4'h0, 16'h000C);
    wr(4'h8, 16'h0000);
    $display("compare test done");
    for (int m = 0; m < 8; m++)
    begin
      wr(4'h0, 16'(m * 16 + 8));
      rd(4'h0, 16'(m * 16 + 8));
      for (int c = -2; c < 3; c++)
      begin
        @(posedge clock);
        counterValue <= 16'(16'h5678 + c);
      end
      cyc(2);
      chk("reference", 16'(m % 2), 16'(channelReferenceOutput));
    end
    wr(4'h0, 16'h0040);
    wr(4'h0, 16'h0010);
    pulse;
    chk("reference", 16'h0, 16'(channelReferenceOutput));
    wr(4'h0, 16'h0014);
    pulse;
    chk("reference", 16'h1, 16'(channelReferenceOutput));
    $display("mode test done");
    report_and_stop;
  end
endmodule
bind ccmc_channel_mode ccmc_channel_mode_checker #(.CNT_W(CNT_W)) CHK (.clock, .rstn,
  .regAddr, .regWrite, .regRead, .regRdata, .counterValue, .updateEvent,
  .channelReferenceOutput, .compareValue);
